// ==== inc/bsc_pkg.sv ====
// constants and types for boot strap capture and boot device sequencing
package bsc_pkg;
    localparam int          STRAP_W      = 16;
    localparam int          AXI_AW       = 4;
    localparam int          AXI_DW       = 32;
    // register byte offsets
    localparam logic [3:0]  REG_STRAP    = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_CTRL     = 4'h8;
    localparam logic [3:0]  REG_DISP     = 4'hC;
    // reset values
    localparam logic [15:0] STRAP_RST    = 16'h0000;
    localparam logic [1:0]  CTRL_RST     = 2'h1;
    localparam logic [15:0] DISP_RST     = 16'h0000;
    // control fields
    localparam int          CTRL_AUTO    = 0;
    localparam int          CTRL_DISP_EN = 1;
    // strap field positions
    localparam int          F_LIST_LSB   = 0;
    localparam int          F_LIST_MSB   = 4;
    localparam int          F_CLKOUT     = 5;
    localparam int          F_ETH_LSB    = 6;
    localparam int          F_ETH_MSB    = 7;
    localparam int          F_BUS16      = 8;
    localparam int          F_ECC        = 9;
    localparam int          F_OSC_LSB    = 14;
    localparam int          F_OSC_MSB    = 15;
    // status fields
    localparam int          S_STATE_LSB  = 0;
    localparam int          S_IDX_LSB    = 4;
    localparam int          S_DEV_LSB    = 8;
    localparam int          S_WARM       = 12;
    localparam int          S_CAPT       = 13;
    // axi responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // boot list codes
    localparam logic [4:0]  BL_00010     = 5'h02;
    localparam logic [4:0]  BL_00110     = 5'h06;
    localparam logic [4:0]  BL_01011     = 5'h0B;
    localparam logic [4:0]  BL_10010     = 5'h12;
    localparam logic [4:0]  BL_10011     = 5'h13;
    localparam logic [4:0]  BL_10100     = 5'h14;
    localparam logic [4:0]  BL_10110     = 5'h16;
    localparam logic [4:0]  BL_10111     = 5'h17;
    localparam logic [4:0]  BL_11000     = 5'h18;
    localparam logic [4:0]  BL_11001     = 5'h19;
    localparam logic [4:0]  BL_11100     = 5'h1C;
    localparam int          LIST_LEN     = 4;

    typedef enum logic [3:0] {
        DEV_NONE     = 4'h0,
        DEV_NAND     = 4'h1,
        DEV_NAND_I2C = 4'h2,
        DEV_SD0      = 4'h3,
        DEV_SD1      = 4'h4,
        DEV_SERIAL0  = 4'h5,
        DEV_SPI_PORT0     = 4'h6,
        DEV_ETH1     = 4'h7,
        DEV_USB_PORT0     = 4'h8
    } bsc_dev_t;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b000,
        ST_PICK = 3'b001,
        ST_POLL = 3'b010,
        ST_LOAD = 3'b011,
        ST_RUN  = 3'b100,
        ST_DEAD = 3'b101
    } bsc_state_t;
endpackage : bsc_pkg

// ==== core/bsc_boot_strap_config.sv ====
// boot strap capture, boot device sequencer and axi4-lite register slave
// What this block does
// R1 - all sixteen straps are captured into the strap field on the rising edge of power_on_reset_n.
// R2 - straps share the display data pins, which are only sampled at that edge and released during reset.
// R3 - strap bits 4 to 0 pick the list of boot devices and their order.
// R4 - strap bit 5 enables driving the oscillator clock out.
// R5 - strap bits 7 and 6 give the ethernet boot phy mode.
// R6 - strap bit 8 says whether the boot device bus is 8 or 16 bits wide.
// R7 - strap bit 9 says whether nand ecc is done by the boot rom or the flash.
// R8 - strap bits 15 and 14 give the oscillator frequency assumed after reset.
// R9 - code 10011 tries nand, nand with eeprom geometry, sd port 0, serial port 0, moving on at each failure.
// R10 - codes 00010, 10110 and 11100 give their listed device orders.
// R11 - the carrier may override strap defaults with stronger resistors during power-on reset.
// R12 - a peripheral source is polled, its image downloaded to internal ram, then executed.
// R13 - memory boot works after cold and warm reset, peripheral boot is skipped after a warm reset.
// R14 - the captured strap field holds until the next power-on reset.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
module bsc_boot_strap_config (
    input  wire logic                       MCLK_IN,
    input  wire logic                       SYS_RST_IN,
    input  wire logic                       POWER_ON_RESET_N_IN,
    input  wire logic                       WARM_RESET_IN,
    input  wire logic [bsc_pkg::STRAP_W-1:0] DISPLAY_DATA_PINS_IN,
    output logic      [bsc_pkg::STRAP_W-1:0] DISPLAY_DATA_PINS_OUT,
    output logic      [bsc_pkg::STRAP_W-1:0] DISPLAY_DATA_PINS_OE_N_OUT,
    output logic                            OSC_CLOCK_OUT_EN_OUT,
    output logic      [1:0]                 ETH_PHY_MODE_OUT,
    output logic                            BOOT_BUS16_OUT,
    output logic                            ECC_SEL_OUT,
    output logic      [1:0]                 OSC_FREQ_SEL_OUT,
    output bsc_pkg::bsc_dev_t               BOOT_DEV_OUT,
    output logic                            BOOT_POLL_OUT,
    output logic                            BOOT_LOAD_OUT,
    output logic                            BOOT_RUN_OUT,
    output logic                            BOOT_DEAD_OUT,
    input  wire logic                       BOOT_FOUND_IN,
    input  wire logic                       BOOT_LOADED_IN,
    input  wire logic                       BOOT_FAIL_IN,
    input  wire logic [bsc_pkg::AXI_AW-1:0] S_AXI_AWADDR_IN,
    input  wire logic                       S_AXI_AWVALID_IN,
    output logic                            S_AXI_AWREADY_OUT,
    input  wire logic [bsc_pkg::AXI_DW-1:0] S_AXI_WDATA_IN,
    input  wire logic [3:0]                 S_AXI_WSTRB_IN,
    input  wire logic                       S_AXI_WVALID_IN,
    output logic                            S_AXI_WREADY_OUT,
    output logic      [1:0]                 S_AXI_BRESP_OUT,
    output logic                            S_AXI_BVALID_OUT,
    input  wire logic                       S_AXI_BREADY_IN,
    input  wire logic [bsc_pkg::AXI_AW-1:0] S_AXI_ARADDR_IN,
    input  wire logic                       S_AXI_ARVALID_IN,
    output logic                            S_AXI_ARREADY_OUT,
    output logic      [bsc_pkg::AXI_DW-1:0] S_AXI_RDATA_OUT,
    output logic      [1:0]                 S_AXI_RRESP_OUT,
    output logic                            S_AXI_RVALID_OUT,
    input  wire logic                       S_AXI_RREADY_IN
);
    import bsc_pkg::*;

    // device order per list code, first device in the low nibble
    function automatic logic [15:0] boot_list(input logic [4:0] code);
        logic [15:0] l;
        l = '0;
        case (code)
            BL_00010: l = {DEV_NAND_I2C, DEV_NAND, DEV_SPI_PORT0, DEV_SERIAL0}; // see R10
            BL_00110: l = {DEV_NAND_I2C, DEV_NAND, DEV_SPI_PORT0, DEV_ETH1};
            BL_01011: l = {DEV_SD0, DEV_SPI_PORT0, DEV_NAND, DEV_USB_PORT0};
            BL_10010: l = {DEV_SERIAL0, DEV_USB_PORT0, DEV_NAND_I2C, DEV_NAND};
            BL_10011: l = {DEV_SERIAL0, DEV_SD0, DEV_NAND_I2C, DEV_NAND}; // see R9
            BL_10100: l = {DEV_ETH1, DEV_SPI_PORT0, DEV_NAND_I2C, DEV_NAND};
            BL_10110: l = {DEV_ETH1, DEV_SERIAL0, DEV_SD0, DEV_SPI_PORT0}; // see R10
            BL_10111: l = {DEV_USB_PORT0, DEV_SERIAL0, DEV_SPI_PORT0, DEV_SD0};
            BL_11000: l = {DEV_SERIAL0, DEV_USB_PORT0, DEV_SD0, DEV_SPI_PORT0};
            BL_11001: l = {DEV_SERIAL0, DEV_ETH1, DEV_SD0, DEV_SPI_PORT0};
            BL_11100: l = {DEV_USB_PORT0, DEV_SERIAL0, DEV_SD0, DEV_SD1}; // see R10
            default:  l = '0;
        endcase
        return l;
    endfunction : boot_list

    // peripheral sources need a download before execution
    function automatic logic is_periph(input bsc_dev_t d);
        return (d == DEV_SERIAL0) || (d == DEV_ETH1) || (d == DEV_USB_PORT0);
    endfunction : is_periph

    // byte-lane merge for 32-bit writes
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    logic       [STRAP_W-1:0] strap_q;
    logic                     capt_q;
    logic                     por_q;
    logic       [1:0]         ctrl_q;
    logic       [STRAP_W-1:0] disp_q;
    bsc_state_t               state_q;
    bsc_state_t               state_d;
    logic       [2:0]         idx_q;
    logic       [2:0]         idx_d;
    logic                     warm_q;
    logic                     warm_d;
    logic                     bvalid_q;
    logic       [1:0]         bresp_q;
    logic                     rvalid_q;
    logic       [1:0]         rresp_q;
    logic       [31:0]        rdata_q;

    wire        por_rise  = POWER_ON_RESET_N_IN & ~por_q;
    wire [15:0] list      = boot_list(strap_q[F_LIST_MSB:F_LIST_LSB]); // see R3
    wire [3:0]  cur_raw   = list[idx_q[1:0]*4 +: 4];
    wire        idx_end   = (idx_q == 3'(LIST_LEN));
    wire        cur_none  = (cur_raw == DEV_NONE);
    wire        cur_per   = is_periph(bsc_dev_t'(cur_raw));
    wire        cur_skip  = cur_none | (warm_q & cur_per);

    // axi decode
    wire        wr_go     = S_AXI_AWVALID_IN & S_AXI_WVALID_IN & ~bvalid_q;
    wire        rd_go     = S_AXI_ARVALID_IN & ~rvalid_q;
    wire        wr_ctrl   = wr_go & (S_AXI_AWADDR_IN == REG_CTRL);
    wire        wr_disp   = wr_go & (S_AXI_AWADDR_IN == REG_DISP);
    wire        wr_ro     = (S_AXI_AWADDR_IN == REG_STRAP) | (S_AXI_AWADDR_IN == REG_STATUS);
    wire        wr_hit    = wr_ro | (S_AXI_AWADDR_IN == REG_CTRL) | (S_AXI_AWADDR_IN == REG_DISP);
    wire [31:0] ctrl_new  = wmerge({30'h0, ctrl_q}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
    wire [31:0] disp_new  = wmerge({16'h0, disp_q}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
    wire [31:0] status_w  = (32'(state_q) << S_STATE_LSB) | (32'(idx_q) << S_IDX_LSB)
                          | (32'(BOOT_DEV_OUT) << S_DEV_LSB) | (32'(warm_q) << S_WARM)
                          | (32'(capt_q) << S_CAPT);
    wire        rd_hit    = (S_AXI_ARADDR_IN == REG_STRAP) | (S_AXI_ARADDR_IN == REG_STATUS)
                          | (S_AXI_ARADDR_IN == REG_CTRL) | (S_AXI_ARADDR_IN == REG_DISP);
    wire [31:0] rd_mux    = (S_AXI_ARADDR_IN == REG_STRAP)  ? {16'h0, strap_q} :
                            (S_AXI_ARADDR_IN == REG_STATUS) ? status_w :
                            (S_AXI_ARADDR_IN == REG_CTRL)   ? {30'h0, ctrl_q} :
                            (S_AXI_ARADDR_IN == REG_DISP)   ? {16'h0, disp_q} : 32'h0;

    // strap capture, held until the next power-on edge
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            por_q   <= 1'b0;
            strap_q <= STRAP_RST;
            capt_q  <= 1'b0;
        end else begin
            por_q <= POWER_ON_RESET_N_IN;
            if (por_rise) begin
                strap_q <= DISPLAY_DATA_PINS_IN; // see R1, R2, R11, R14
                capt_q  <= 1'b1;
            end
        end
    end

    // strap-driven configuration outputs
    assign OSC_CLOCK_OUT_EN_OUT = strap_q[F_CLKOUT]; // see R4
    assign ETH_PHY_MODE_OUT     = strap_q[F_ETH_MSB:F_ETH_LSB]; // see R5
    assign BOOT_BUS16_OUT       = strap_q[F_BUS16]; // see R6
    assign ECC_SEL_OUT          = strap_q[F_ECC]; // see R7
    assign OSC_FREQ_SEL_OUT     = strap_q[F_OSC_MSB:F_OSC_LSB]; // see R8

    // display pins released while in power-on reset so straps can be read
    wire   disp_drive = POWER_ON_RESET_N_IN & ctrl_q[CTRL_DISP_EN]; // see R2
    assign DISPLAY_DATA_PINS_OUT      = disp_q;
    assign DISPLAY_DATA_PINS_OE_N_OUT = {STRAP_W{~disp_drive}};

    // boot sequencer
    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        warm_d  = warm_q;
        case (state_q)
            ST_WAIT: begin
                if (capt_q & ctrl_q[CTRL_AUTO] & POWER_ON_RESET_N_IN) begin
                    state_d = ST_PICK;
                    idx_d   = '0;
                end
            end
            ST_PICK: begin
                if (idx_end) begin
                    state_d = ST_DEAD;
                end else if (cur_skip) begin
                    idx_d = idx_q + 3'h1; // see R13
                end else begin
                    state_d = ST_POLL;
                end
            end
            ST_POLL: begin
                if (BOOT_FAIL_IN) begin
                    state_d = ST_PICK;
                    idx_d   = idx_q + 3'h1; // see R9
                end else if (BOOT_FOUND_IN) begin
                    state_d = cur_per ? ST_LOAD : ST_RUN; // see R12
                end
            end
            ST_LOAD: begin
                if (BOOT_FAIL_IN) begin
                    state_d = ST_PICK;
                    idx_d   = idx_q + 3'h1;
                end else if (BOOT_LOADED_IN) begin
                    state_d = ST_RUN; // see R12
                end
            end
            ST_RUN:  state_d = ST_RUN;
            ST_DEAD: state_d = ST_DEAD;
            default: state_d = ST_WAIT;
        endcase
        if (!POWER_ON_RESET_N_IN) begin
            state_d = ST_WAIT;
            warm_d  = 1'b0;
        end else if (WARM_RESET_IN & capt_q) begin
            state_d = ST_PICK; // see R13
            idx_d   = '0;
            warm_d  = 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state_q <= ST_WAIT;
            idx_q   <= '0;
            warm_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q   <= idx_d;
            warm_q  <= warm_d;
        end
    end

    // decoded from next state so status outputs leave straight from flops
    wire       act_d = (state_d == ST_POLL) | (state_d == ST_LOAD) | (state_d == ST_RUN);
    wire [3:0] dev_d = act_d ? list[idx_d[1:0]*4 +: 4] : DEV_NONE; // see R3

    bsc_dev_t  dev_q;
    logic      poll_q;
    logic      load_q;
    logic      run_q;
    logic      dead_q;

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            dev_q  <= DEV_NONE;
            poll_q <= 1'b0;
            load_q <= 1'b0;
            run_q  <= 1'b0;
            dead_q <= 1'b0;
        end else begin
            dev_q  <= bsc_dev_t'(dev_d);
            poll_q <= (state_d == ST_POLL);
            load_q <= (state_d == ST_LOAD); // see R12
            run_q  <= (state_d == ST_RUN);
            dead_q <= (state_d == ST_DEAD);
        end
    end

    assign BOOT_DEV_OUT  = dev_q;
    assign BOOT_POLL_OUT = poll_q;
    assign BOOT_LOAD_OUT = load_q;
    assign BOOT_RUN_OUT  = run_q;
    assign BOOT_DEAD_OUT = dead_q;

    // register writes
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            ctrl_q <= CTRL_RST;
            disp_q <= DISP_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_new[1:0];
            end
            if (wr_disp) begin
                disp_q <= disp_new[15:0];
            end
        end
    end

    // write response
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY_IN) begin
            bvalid_q <= 1'b0;
        end
    end

    // read response
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_q  <= rd_mux;
        end else if (S_AXI_RREADY_IN) begin
            rvalid_q <= 1'b0;
        end
    end

    assign S_AXI_AWREADY_OUT = wr_go;
    assign S_AXI_WREADY_OUT  = wr_go;
    assign S_AXI_BVALID_OUT  = bvalid_q;
    assign S_AXI_BRESP_OUT   = bresp_q;
    assign S_AXI_ARREADY_OUT = rd_go;
    assign S_AXI_RVALID_OUT  = rvalid_q;
    assign S_AXI_RRESP_OUT   = rresp_q;
    assign S_AXI_RDATA_OUT   = rdata_q;
endmodule : bsc_boot_strap_config

// ==== dv/bsc_strap_board.sv ====
// board strap resistors and carrier overrides on the shared display pins
module bsc_strap_board (
    input  wire logic [15:0] dflt_in,
    input  wire logic [15:0] ovr_mask_in,
    input  wire logic [15:0] ovr_val_in,
    input  wire logic [15:0] oe_n_in,
    input  wire logic [15:0] drive_in,
    output logic      [15:0] pins_out
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic [15:0] pulled = (ovr_mask_in & ovr_val_in) | (~ovr_mask_in & dflt_in);
    // released pins settle to the resistor level, driven pins follow the device
    assign pins_out = (~oe_n_in & drive_in) | (oe_n_in & pulled);
endmodule : bsc_strap_board

// ==== dv/bsc_strap_monitor.sv ====
// assertions on strap capture, pin release and boot source kinds
module bsc_strap_monitor (
    input wire logic                          MCLK_IN,
    input wire logic                          SYS_RST_IN,
    input wire logic                          POWER_ON_RESET_N_IN,
    input wire logic [bsc_pkg::STRAP_W-1:0]   DISPLAY_DATA_PINS_IN,
    input wire logic [bsc_pkg::STRAP_W-1:0]   DISPLAY_DATA_PINS_OE_N_OUT,
    input wire logic                          OSC_CLOCK_OUT_EN_OUT,
    input wire logic [1:0]                    ETH_PHY_MODE_OUT,
    input wire logic                          BOOT_BUS16_OUT,
    input wire logic                          ECC_SEL_OUT,
    input wire logic [1:0]                    OSC_FREQ_SEL_OUT,
    input wire bsc_pkg::bsc_dev_t             BOOT_DEV_OUT,
    input wire logic                          BOOT_POLL_OUT,
    input wire logic                          BOOT_LOAD_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    import bsc_pkg::*;
    logic        por_q;
    logic [15:0] pins_q;
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            por_q  <= 1'b0;
            pins_q <= 16'h0000;
        end else begin
            por_q  <= POWER_ON_RESET_N_IN;
            pins_q <= DISPLAY_DATA_PINS_IN;
        end
    end
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence cap_s;
        !por_q && POWER_ON_RESET_N_IN;
    endsequence
    sequence quiet_s;
        !(!por_q && POWER_ON_RESET_N_IN);
    endsequence
    clk_out_a: assert property (cap_s |=> OSC_CLOCK_OUT_EN_OUT == pins_q[5])
        else $error("clock out enable differs from strap");
    eth_mode_a: assert property (cap_s |=> ETH_PHY_MODE_OUT == pins_q[7:6])
        else $error("phy mode differs from strap");
    bus_width_a: assert property (cap_s |=> BOOT_BUS16_OUT == pins_q[8])
        else $error("bus width differs from strap");
    ecc_sel_a: assert property (cap_s |=> ECC_SEL_OUT == pins_q[9])
        else $error("ecc select differs from strap");
    osc_freq_a: assert property (cap_s |=> OSC_FREQ_SEL_OUT == pins_q[15:14])
        else $error("oscillator select differs from strap");
    pins_free_a: assert property (!POWER_ON_RESET_N_IN |-> &DISPLAY_DATA_PINS_OE_N_OUT)
        else $error("pins driven during power-on reset");
    field_hold_a: assert property (quiet_s |=> $stable({OSC_CLOCK_OUT_EN_OUT, ETH_PHY_MODE_OUT,
        BOOT_BUS16_OUT, ECC_SEL_OUT, OSC_FREQ_SEL_OUT})) else $error("strap outputs changed without capture");
    load_kind_a: assert property (BOOT_LOAD_OUT |-> BOOT_DEV_OUT inside {DEV_SERIAL0, DEV_ETH1, DEV_USB_PORT0})
        else $error("download from a memory device");
    poll_dev_a: assert property (BOOT_POLL_OUT |-> BOOT_DEV_OUT != DEV_NONE)
        else $error("polling with no device");
endmodule : bsc_strap_monitor

// ==== dv/testbench.sv ====
// self-checking bench for strap capture, boot order and register access
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import bsc_pkg::*;
    logic        clk, rst, por_n, warm, found, loaded, fail, clko, b16, ecc, poll, load, run, dead;
    logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  eth, freq, bresp, rresp;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [15:0] dflt, omask, oval, pout, oe_n;
    logic [31:0] wdata, rdata;
    wire  [15:0] pins;
    wire  [3:0]  st = {dead, run, load, poll};
    bsc_dev_t    dev;
    int          failures, total_checks, cycles;
    logic [15:0] tv[5] = '{16'h4013, 16'h0013, 16'h801C, 16'h0000, 16'hC016};
    logic [15:0] tm[5] = '{16'h0000, 16'h03FF, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] to[5] = '{16'h0000, 16'h03E2, 16'h0000, 16'h0000, 16'h0000};
    int          th[5] = '{2, 0, -1, -1, 3};
    bsc_boot_strap_config u_bsc_boot_strap_config (.MCLK_IN(clk), .SYS_RST_IN(rst), .POWER_ON_RESET_N_IN(por_n),
        .WARM_RESET_IN(warm), .DISPLAY_DATA_PINS_IN(pins), .DISPLAY_DATA_PINS_OUT(pout),
        .DISPLAY_DATA_PINS_OE_N_OUT(oe_n), .OSC_CLOCK_OUT_EN_OUT(clko), .ETH_PHY_MODE_OUT(eth),
        .BOOT_BUS16_OUT(b16), .ECC_SEL_OUT(ecc), .OSC_FREQ_SEL_OUT(freq), .BOOT_DEV_OUT(dev),
        .BOOT_POLL_OUT(poll), .BOOT_LOAD_OUT(load), .BOOT_RUN_OUT(run), .BOOT_DEAD_OUT(dead),
        .BOOT_FOUND_IN(found), .BOOT_LOADED_IN(loaded), .BOOT_FAIL_IN(fail), .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
        .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));
    bsc_strap_board u_bsc_strap_board (.dflt_in(dflt), .ovr_mask_in(omask), .ovr_val_in(oval),
        .oe_n_in(oe_n), .drive_in(pout), .pins_out(pins));
    task automatic stop_test();
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin @(posedge clk); end while (!(awready && wready));
        awvalid <= 1'b0; wvalid <= 1'b0;
        while (!bvalid) begin @(posedge clk); end
        bready <= 1'b0;
        check(bresp, RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin @(posedge clk); end while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) begin @(posedge clk); end
        rready <= 1'b0;
        d = rdata;
        check(rresp, RESP_OKAY);
    endtask : rd
    task automatic wait_st(input int k);
        int n;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (st[k] !== 1'b1 && n < 200);
        check(st[k], 1'b1);
    endtask : wait_st
    task automatic pulse(input logic [2:0] v);
        @(posedge clk);
        {fail, found, loaded} <= v;
        @(posedge clk);
        {fail, found, loaded} <= 3'b000;
    endtask : pulse
    function automatic logic [15:0] order(input logic [4:0] c);
        case (c)
            BL_10011: return {DEV_NAND, DEV_NAND_I2C, DEV_SD0, DEV_SERIAL0};
            BL_00010: return {DEV_SERIAL0, DEV_SPI_PORT0, DEV_NAND, DEV_NAND_I2C};
            BL_10110: return {DEV_SPI_PORT0, DEV_SD0, DEV_SERIAL0, DEV_ETH1};
            BL_11100: return {DEV_SD1, DEV_SD0, DEV_SERIAL0, DEV_USB_PORT0};
            default:  return 16'h0000;
        endcase
    endfunction : order
    task automatic boot(input logic [4:0] c, input logic w, input int hit);
        logic [15:0] l;
        bsc_dev_t    e;
        logic        per;
        int          k;
        l = order(c);
        k = 0;
        for (int i = 0; i < LIST_LEN; i++) begin
            e = bsc_dev_t'(l[15-4*i -: 4]);
            per = e inside {DEV_SERIAL0, DEV_ETH1, DEV_USB_PORT0};
            if (e == DEV_NONE || (w && per)) continue;
            wait_st(0);
            check(dev, e);
            if (k == hit) begin
                pulse(3'b010);
                if (per) begin
                    wait_st(1);
                    pulse(3'b001);
                end
                wait_st(2);
                check(dev, e);
                return;
            end
            pulse(3'b100);
            k++;
        end
        wait_st(3);
    endtask : boot
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        logic [31:0] d;
        logic [15:0] s;
        rst = 1'b1; por_n = 1'b0; warm = 1'b0; {fail, found, loaded} = 3'b000; dflt = 16'h0000;
        omask = 16'h0000; oval = 16'h0000; awaddr = 4'h0; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
        wvalid = 1'b0; bready = 1'b0; araddr = 4'h0; arvalid = 1'b0; rready = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(REG_CTRL, d);
        check(d, {30'h0, CTRL_RST});
        rd(REG_DISP, d);
        check(d, {16'h0, DISP_RST});
        wr(REG_STRAP, 32'h0000FFFF);
        rd(REG_STRAP, d);
        check(d, {16'h0, STRAP_RST});
        for (int i = 0; i < 5; i++) begin
            s = (tv[i] & ~tm[i]) | (to[i] & tm[i]);
            @(posedge clk);
            por_n <= 1'b0; dflt <= tv[i]; omask <= tm[i]; oval <= to[i];
            repeat (3) @(posedge clk);
            por_n <= 1'b1;
            repeat (3) @(posedge clk);
            #1;
            check(clko, s[5]);
            check(eth, s[7:6]);
            check(b16, s[8]);
            check(ecc, s[9]);
            check(freq, s[15:14]);
            rd(REG_STRAP, d);
            check(d, {16'h0, s});
            boot(s[4:0], 1'b0, th[i]);
        end
        @(posedge clk) warm <= 1'b1;
        @(posedge clk) warm <= 1'b0;
        boot(s[4:0], 1'b1, -1);
        wr(REG_DISP, 32'h0000A5F0);
        wr(REG_CTRL, 32'h00000003);
        @(posedge clk);
        #1;
        check(oe_n, 32'h0);
        check(pins, 32'h0000A5F0);
        rd(REG_STRAP, d);
        check(d, {16'h0, s});
        check(freq, s[15:14]);
        rd(REG_STATUS, d);
        check(d, (32'(ST_DEAD) << S_STATE_LSB) | (32'(LIST_LEN) << S_IDX_LSB)
            | (32'h1 << S_WARM) | (32'h1 << S_CAPT));
        stop_test();
    end
endmodule : testbench
bind bsc_boot_strap_config bsc_strap_monitor u_bsc_strap_monitor (.MCLK_IN, .SYS_RST_IN, .POWER_ON_RESET_N_IN,
    .DISPLAY_DATA_PINS_IN, .DISPLAY_DATA_PINS_OE_N_OUT, .OSC_CLOCK_OUT_EN_OUT, .ETH_PHY_MODE_OUT,
    .BOOT_BUS16_OUT, .ECC_SEL_OUT, .OSC_FREQ_SEL_OUT, .BOOT_DEV_OUT, .BOOT_POLL_OUT, .BOOT_LOAD_OUT);
